/* File: mrf_cfg.svh */
// address map, reset values and selector codes of the macrocell fabric slice
`ifndef MRF_CFG_SVH
`define MRF_CFG_SVH

// ----------------------------------------------------------------------------
// register byte addresses (apb, one aligned 32-bit word each)
// ----------------------------------------------------------------------------
`define MRF_ADDR_ROUTE    12'h000
`define MRF_ADDR_GCLK     12'h004
`define MRF_ADDR_STATUS   12'h008
`define MRF_ADDR_MC       12'h040
`define MRF_ADDR_IO       12'h080
`define MRF_ADDR_OE       12'h0c0
`define MRF_ADDR_PT       12'h100
`define MRF_ADDR_END      12'h400

// word and product-term strides in bytes
`define MRF_WORD_BYTES    4
`define MRF_PT_BYTES      8

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define MRF_RST_CFG       32'h0000_0000
`define MRF_RST_RDATA     32'h0000_0000

// ----------------------------------------------------------------------------
// output enable selector codes of each pin
// ----------------------------------------------------------------------------
`define MRF_OE_SEL_OFF    4'h0
`define MRF_OE_SEL_ON     4'h1
`define MRF_OE_SEL_NET0   4'h2

// ----------------------------------------------------------------------------
// dedicated input positions and product-term roles inside a macrocell
// ----------------------------------------------------------------------------
`define MRF_DED_CLK_A     0
`define MRF_DED_CLK_B     1
`define MRF_DED_OE_A      2
`define MRF_DED_CLR_LOW   3
`define MRF_NUM_DED       4
`define MRF_PT_SUM0       0
`define MRF_PT_SUM1       1
`define MRF_PT_SHARE      2
`define MRF_PT_CLK        3
`define MRF_PT_PRESET     4
`define MRF_PT_CLEAR      5

`endif

/* File: mrf_pkg.sv */
// types of the macrocell fabric slice
package mrf_pkg;

	// storage element behaviour
	typedef enum logic [1:0] {
		FF_D,
		FF_T,
		FF_JK,
		FF_SR
	} mrf_ff_kind_type;

	// clock source of a macrocell register
	typedef enum logic [1:0] {
		CLK_GLOBAL,
		CLK_GATED,
		CLK_ARRAY
	} mrf_clk_mode_type;

	// pin direction
	typedef enum logic [1:0] {
		IO_INPUT,
		IO_OUTPUT,
		IO_BIDIR
	} mrf_io_mode_type;

	// register groups seen by the bus decoder
	typedef enum logic [2:0] {
		REG_NONE,
		REG_ROUTE,
		REG_GCLK,
		REG_STATUS,
		REG_MC,
		REG_IO,
		REG_OE,
		REG_PT
	} mrf_reg_type;

	// per-macrocell configuration word, bits 9:0
	typedef struct packed {
		logic             lend;
		logic             fast_dly;
		logic             fast_in;
		logic             gclr_en;
		logic             gclk_sel;
		mrf_clk_mode_type clk_mode;
		logic             bypass;
		mrf_ff_kind_type  kind;
	} mrf_mc_cfg_type;

	// per-pin configuration word, bits 5:0
	typedef struct packed {
		logic [3:0]      oe_sel;
		mrf_io_mode_type mode;
	} mrf_io_cfg_type;

	// global output enable net source, bits 5:0
	typedef struct packed {
		logic       inv;
		logic [4:0] src;
	} mrf_oe_cfg_type;

	// global clock net source, two bits each
	typedef struct packed {
		logic inv;
		logic pin;
	} mrf_gclk_cfg_type;

endpackage

/* File: mrf_fabric.sv */
// macrocell register, routing array and i/o control slice with apb configuration
//
// Function
// - each macrocell register acts as d, t, jk or sr, chosen per cell.
// - bypass setting passes the logic result straight to the output.
// - three clock choices: global, gated global, or array clock.
// - gated global clock captures only when the enable product term is high.
// - array clock comes from a product term, fed by cells or pins.
// - two global clock nets, each true or inverted of either clock pin.
// - preset and clear product terms act asynchronously, active high.
// - per register, the global clear input clears while it is low.
// - each register powers up at its own chosen high or low level.
// - each pin has a direct path into its macrocell d register.
// - fast path delay on gives zero hold, off gives shortest setup.
// - unused product term may be lent to the next macrocell.
// - dedicated inputs, pin inputs and cell outputs all feed routing array; here output-only pins feed it low.
// - each routing signal enters the block through an and with a config bit.
// - each pin is input only, output only or bidirectional.
// - pin driver enabled by one global enable net or tied on or off.
// - six or ten global enable nets from dedicated inputs, pins or cells.
// - four dedicated inputs: clock, clear, enable sources and general inputs.
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "mrf_cfg.svh"

module mrf_fabric import mrf_pkg::*; #(
	parameter int                 NUM_CELL      = 8,
	parameter int                 PT_PER_MC     = 6,
	parameter int                 NUM_OE        = 6,
	parameter logic [NUM_CELL-1:0] POWERUP_STATE = '0
) (
	input  wire logic                core_clk_in,
	input  wire logic                rst_b_in,
	input  wire logic                global_clock_pin_a_in,
	input  wire logic                global_clock_pin_b_in,
	input  wire logic                oe_pin_a_in,
	input  wire logic                global_clear_low_in,
	input  wire logic [NUM_CELL-1:0] io_pin_in,
	output logic      [NUM_CELL-1:0] io_pin_out,
	output logic      [NUM_CELL-1:0] io_pin_oe_out,
	input  wire logic                psel_in,
	input  wire logic                penable_in,
	input  wire logic                pwrite_in,
	input  wire logic [11:0]         paddr_in,
	input  wire logic [31:0]         pwdata_in,
	output logic      [31:0]         prdata_out,
	output logic                     pready_out,
	output logic                     pslverr_out
);

	localparam int NUM_SRC = `MRF_NUM_DED + 2 * NUM_CELL;
	localparam int NUM_PT  = NUM_CELL * PT_PER_MC;

	// ------------------------------------------------------------------------
	// configuration storage
	// ------------------------------------------------------------------------
	logic             [NUM_SRC-1:0] route_q;
	mrf_gclk_cfg_type [1:0]         gclk_cfg_q;
	mrf_mc_cfg_type                 mc_cfg_q [NUM_CELL];
	mrf_io_cfg_type                 io_cfg_q [NUM_CELL];
	mrf_oe_cfg_type                 oe_cfg_q [NUM_OE];
	logic             [NUM_SRC-1:0] pt_true_q [NUM_PT];
	logic             [NUM_SRC-1:0] pt_comp_q [NUM_PT];

	// ------------------------------------------------------------------------
	// internal signals
	// ------------------------------------------------------------------------
	logic [`MRF_NUM_DED-1:0] ded_s1_q;
	logic [`MRF_NUM_DED-1:0] ded_s2_q;
	logic [NUM_CELL-1:0]     pin_s1_q;
	logic [NUM_CELL-1:0]     pin_s2_q;
	logic [NUM_CELL-1:0]     pin_s3_q;
	logic [NUM_CELL-1:0]     pin_route;
	logic [NUM_CELL-1:0]     mc_out;
	logic [NUM_CELL-1:0]     mc_fb_q;
	logic [NUM_SRC-1:0]      src_vec;
	logic [NUM_SRC-1:0]      lab_in;
	logic [NUM_PT-1:0]       pt;
	logic [1:0]              gnet;
	logic [1:0]              gnet_q;
	logic [1:0]              gedge;
	logic [NUM_OE-1:0]       oe_net;
	mrf_reg_type             reg_sel;
	int                      reg_idx;
	logic                    reg_hi;
	logic                    bus_wr;
	logic                    bus_setup;
	logic [31:0]             rd_data;

	// ------------------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------------------

	// two stages before any logic; third pin stage is the fast path delay
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ded_s1_q <= '0;
			ded_s2_q <= '0;
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
		end else begin
			ded_s1_q <= {global_clear_low_in, oe_pin_a_in,
				global_clock_pin_b_in, global_clock_pin_a_in};
			ded_s2_q <= ded_s1_q;
			pin_s1_q <= io_pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	// ------------------------------------------------------------------------
	// global routing array
	// ------------------------------------------------------------------------

	// output-only pins do not feed the array
	always_comb begin
		for (int i = 0; i < NUM_CELL; i++) begin
			pin_route[i] = pin_s2_q[i] && (io_cfg_q[i].mode != IO_OUTPUT);
		end
	end

	// cell feedback is flopped so a bypassed cell can never close a loop
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			mc_fb_q <= '0;
		end else begin
			mc_fb_q <= mc_out;
		end
	end

	// every source drives the array, each gated into the block
	assign src_vec = {mc_fb_q, pin_route, ded_s2_q};
	assign lab_in  = src_vec & route_q;

	// ------------------------------------------------------------------------
	// product terms
	// ------------------------------------------------------------------------

	// an unprogrammed term (no literal) reads low
	genvar p;
	generate
		for (p = 0; p < NUM_PT; p++) begin : g_pt
			assign pt[p] = (|(pt_true_q[p] | pt_comp_q[p]))
				&& (&(~pt_true_q[p] | lab_in))
				&& (&(~pt_comp_q[p] | ~lab_in));
		end
	endgenerate

	// ------------------------------------------------------------------------
	// global clock nets
	// ------------------------------------------------------------------------

	// each net picks either clock pin, true or inverted; edges by sampling
	always_comb begin
		for (int k = 0; k < 2; k++) begin
			gnet[k] = (gclk_cfg_q[k].pin ? ded_s2_q[`MRF_DED_CLK_B]
				: ded_s2_q[`MRF_DED_CLK_A]) ^ gclk_cfg_q[k].inv;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gnet_q <= '0;
		end else begin
			gnet_q <= gnet;
		end
	end

	assign gedge = gnet & ~gnet_q;

	// ------------------------------------------------------------------------
	// macrocells
	// ------------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < NUM_CELL; i++) begin : g_mc
			localparam int B = i * PT_PER_MC;
			logic ff_q;
			logic aclk_q;
			logic lend_in;
			logic two_in;
			logic sum_a;
			logic in_b;
			logic ff_nxt;
			logic d_fast;
			logic clk_ev;
			logic clr;
			logic pre;

			// share term borrowed from the cell below
			if (i > 0) begin : g_lend
				assign lend_in = mc_cfg_q[i-1].lend && pt[B - PT_PER_MC + `MRF_PT_SHARE];
			end else begin : g_nolend
				assign lend_in = 1'b0;
			end

			// jk and sr take the share term as their second input
			assign two_in = (mc_cfg_q[i].kind == FF_JK) || (mc_cfg_q[i].kind == FF_SR);
			assign sum_a  = pt[B + `MRF_PT_SUM0] || pt[B + `MRF_PT_SUM1] || lend_in
				|| (pt[B + `MRF_PT_SHARE] && !mc_cfg_q[i].lend && !two_in);
			assign in_b   = pt[B + `MRF_PT_SHARE] && !mc_cfg_q[i].lend && two_in;

			// register behaviour per type; sr with both high holds
			always_comb begin
				case (mc_cfg_q[i].kind)
					FF_D:    ff_nxt = sum_a;
					FF_T:    ff_nxt = ff_q ^ sum_a;
					FF_JK:   ff_nxt = (sum_a && !ff_q) || (!in_b && ff_q);
					FF_SR:   ff_nxt = (sum_a && !in_b) || (ff_q && !(in_b && !sum_a));
					default: ff_nxt = ff_q;
				endcase
			end

			// fast path straight from the pin, optional extra stage
			assign d_fast = mc_cfg_q[i].fast_dly ? pin_s3_q[i] : pin_s2_q[i];

			// clock choice; gated mode holds when the enable term is low
			always_comb begin
				case (mc_cfg_q[i].clk_mode)
					CLK_GLOBAL: clk_ev = gedge[mc_cfg_q[i].gclk_sel];
					CLK_GATED:  clk_ev = gedge[mc_cfg_q[i].gclk_sel]
						&& pt[B + `MRF_PT_CLK];
					CLK_ARRAY:  clk_ev = pt[B + `MRF_PT_CLK] && !aclk_q;
					default:    clk_ev = 1'b0;
				endcase
			end

			// previous array clock level for its rising edge
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					aclk_q <= 1'b0;
				end else begin
					aclk_q <= pt[B + `MRF_PT_CLK];
				end
			end

			// clear wins over preset; both override any clock
			assign clr = pt[B + `MRF_PT_CLEAR]
				|| (mc_cfg_q[i].gclr_en && !ded_s2_q[`MRF_DED_CLR_LOW]);
			assign pre = pt[B + `MRF_PT_PRESET];

			// power-up level is a per-cell constant
			always_ff @(posedge core_clk_in or negedge rst_b_in) begin
				if (!rst_b_in) begin
					ff_q <= POWERUP_STATE[i];
				end else if (clr) begin
					ff_q <= 1'b0;
				end else if (pre) begin
					ff_q <= 1'b1;
				end else if (clk_ev) begin
					ff_q <= mc_cfg_q[i].fast_in ? d_fast : ff_nxt;
				end
			end

			assign mc_out[i] = mc_cfg_q[i].bypass ? sum_a : ff_q;
		end
	endgenerate

	// ------------------------------------------------------------------------
	// output enable nets and pins
	// ------------------------------------------------------------------------
	genvar k;
	generate
		for (k = 0; k < NUM_OE; k++) begin : g_oe
			// any array source, true or inverted; out of range reads as the inv bit
			assign oe_net[k] = ((int'(oe_cfg_q[k].src) < NUM_SRC)
				? src_vec[oe_cfg_q[k].src] : 1'b0) ^ oe_cfg_q[k].inv;
		end

		for (k = 0; k < NUM_CELL; k++) begin : g_pin
			logic drv;
			int   net;

			assign net = int'(io_cfg_q[k].oe_sel) - int'(`MRF_OE_SEL_NET0);

			// tied off, tied on, or one selected net
			always_comb begin
				if (io_cfg_q[k].oe_sel == `MRF_OE_SEL_OFF) begin
					drv = 1'b0;
				end else if (io_cfg_q[k].oe_sel == `MRF_OE_SEL_ON) begin
					drv = 1'b1;
				end else if (net < NUM_OE) begin
					drv = oe_net[net];
				end else begin
					drv = 1'b0;
				end
			end

			// input-only pins never drive
			assign io_pin_oe_out[k] = drv && (io_cfg_q[k].mode == IO_OUTPUT
				|| io_cfg_q[k].mode == IO_BIDIR);
			assign io_pin_out[k] = mc_out[k];
		end
	endgenerate

	// ------------------------------------------------------------------------
	// apb slave
	// ------------------------------------------------------------------------

	// address decode into group and index; misaligned is unmapped
	always_comb begin
		reg_sel = REG_NONE;
		reg_idx = 0;
		reg_hi  = paddr_in[2];
		if (paddr_in[1:0] != 2'b00) begin
			reg_sel = REG_NONE;
		end else if (paddr_in == `MRF_ADDR_ROUTE) begin
			reg_sel = REG_ROUTE;
		end else if (paddr_in == `MRF_ADDR_GCLK) begin
			reg_sel = REG_GCLK;
		end else if (paddr_in == `MRF_ADDR_STATUS) begin
			reg_sel = REG_STATUS;
		end else if (paddr_in >= `MRF_ADDR_MC && paddr_in < `MRF_ADDR_IO) begin
			reg_idx = int'(paddr_in - `MRF_ADDR_MC) / `MRF_WORD_BYTES;
			reg_sel = (reg_idx < NUM_CELL) ? REG_MC : REG_NONE;
		end else if (paddr_in >= `MRF_ADDR_IO && paddr_in < `MRF_ADDR_OE) begin
			reg_idx = int'(paddr_in - `MRF_ADDR_IO) / `MRF_WORD_BYTES;
			reg_sel = (reg_idx < NUM_CELL) ? REG_IO : REG_NONE;
		end else if (paddr_in >= `MRF_ADDR_OE && paddr_in < `MRF_ADDR_PT) begin
			reg_idx = int'(paddr_in - `MRF_ADDR_OE) / `MRF_WORD_BYTES;
			reg_sel = (reg_idx < NUM_OE) ? REG_OE : REG_NONE;
		end else if (paddr_in >= `MRF_ADDR_PT && paddr_in < `MRF_ADDR_END) begin
			reg_idx = int'(paddr_in - `MRF_ADDR_PT) / `MRF_PT_BYTES;
			reg_sel = (reg_idx < NUM_PT) ? REG_PT : REG_NONE;
		end
	end

	// read mux; status shows flopped cell feedback and synchronised pin levels
	always_comb begin
		case (reg_sel)
			REG_ROUTE:  rd_data = 32'(route_q);
			REG_GCLK:   rd_data = 32'(gclk_cfg_q);
			REG_STATUS: rd_data = 32'({pin_s2_q, mc_fb_q});
			REG_MC:     rd_data = 32'(mc_cfg_q[reg_idx]);
			REG_IO:     rd_data = 32'(io_cfg_q[reg_idx]);
			REG_OE:     rd_data = 32'(oe_cfg_q[reg_idx]);
			REG_PT:     rd_data = reg_hi ? 32'(pt_comp_q[reg_idx]) : 32'(pt_true_q[reg_idx]);
			default:    rd_data = `MRF_RST_RDATA;
		endcase
	end

	assign bus_setup  = psel_in && !penable_in;
	assign bus_wr     = psel_in && penable_in && pwrite_in && (reg_sel != REG_NONE);
	assign pready_out = 1'b1; // zero wait: answer in the first access cycle

	// read data and error captured in setup so they come from flops
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			prdata_out  <= `MRF_RST_RDATA;
			pslverr_out <= 1'b0;
		end else if (bus_setup) begin
			prdata_out  <= pwrite_in ? `MRF_RST_RDATA : rd_data;
			pslverr_out <= (reg_sel == REG_NONE);
		end
	end

	// configuration writes; status is read-only and writes to it are dropped
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			route_q    <= NUM_SRC'(`MRF_RST_CFG);
			gclk_cfg_q <= 4'(`MRF_RST_CFG);
			for (int n = 0; n < NUM_CELL; n++) begin
				mc_cfg_q[n] <= mrf_mc_cfg_type'(10'(`MRF_RST_CFG));
				io_cfg_q[n] <= mrf_io_cfg_type'(6'(`MRF_RST_CFG));
			end
			for (int n = 0; n < NUM_OE; n++) begin
				oe_cfg_q[n] <= mrf_oe_cfg_type'(6'(`MRF_RST_CFG));
			end
			for (int n = 0; n < NUM_PT; n++) begin
				pt_true_q[n] <= NUM_SRC'(`MRF_RST_CFG);
				pt_comp_q[n] <= NUM_SRC'(`MRF_RST_CFG);
			end
		end else if (bus_wr) begin
			case (reg_sel)
				REG_ROUTE: route_q <= pwdata_in[NUM_SRC-1:0];
				REG_GCLK:  gclk_cfg_q <= pwdata_in[3:0];
				REG_MC:    mc_cfg_q[reg_idx] <= mrf_mc_cfg_type'(pwdata_in[9:0]);
				REG_IO:    io_cfg_q[reg_idx] <= mrf_io_cfg_type'(pwdata_in[5:0]);
				REG_OE:    oe_cfg_q[reg_idx] <= mrf_oe_cfg_type'(pwdata_in[5:0]);
				REG_PT: begin
					if (reg_hi) begin
						pt_comp_q[reg_idx] <= pwdata_in[NUM_SRC-1:0];
					end else begin
						pt_true_q[reg_idx] <= pwdata_in[NUM_SRC-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

endmodule

/* File: mrf_fabric_monitor.sv */
// port-level assertion checker of the macrocell fabric slice
`timescale 1ns/1ps
module mrf_fabric_monitor import mrf_pkg::*; #(
	parameter int NUM_CELL = 8
) (
	input wire logic                core_clk_in,
	input wire logic                rst_b_in,
	input wire logic                global_clear_low_in,
	input wire logic [NUM_CELL-1:0] io_pin_in,
	input wire logic [NUM_CELL-1:0] io_pin_out,
	input wire logic [NUM_CELL-1:0] io_pin_oe_out,
	input wire logic                psel_in,
	input wire logic                penable_in,
	input wire logic                pwrite_in,
	input wire logic [11:0]         paddr_in,
	input wire logic [31:0]         pwdata_in,
	input wire logic [31:0]         prdata_out,
	input wire logic                pready_out,
	input wire logic                pslverr_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	// --------------------------------------------------------------
	// shadow of the pin and cell configuration
	// --------------------------------------------------------------
	logic [5:0]          io_q [NUM_CELL];
	logic [NUM_CELL-1:0] gclr_q;
	logic [NUM_CELL-1:0] byp_q;
	wire                 wr_acc = psel_in && penable_in && pwrite_in && paddr_in[1:0] == 2'h0;
	wire                 setup  = psel_in && !penable_in;

	// snoop writes so that config-dependent pin rules can be judged
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			for (int i = 0; i < NUM_CELL; i++) io_q[i] <= 6'h00;
			gclr_q <= '0;
			byp_q <= '0;
		end else if (wr_acc && paddr_in[11:5] == 7'h04) begin
			io_q[paddr_in[4:2]] <= pwdata_in[5:0];
		end else if (wr_acc && paddr_in[11:5] == 7'h02) begin
			gclr_q[paddr_in[4:2]] <= pwdata_in[6];
			byp_q[paddr_in[4:2]] <= pwdata_in[2];
		end
	end

	// --------------------------------------------------------------
	// sequences and assertions
	// --------------------------------------------------------------
	sequence s_rd_setup(logic [11:0] a);
		setup && !pwrite_in && paddr_in == a;
	endsequence

	sequence s_pins_calm;
		$stable(io_pin_in) [*3];
	endsequence

	AST_READY: assert property (setup |=> pready_out)
		else $error("no ready in access phase");
	AST_ERR_BAD: assert property (setup && (paddr_in[1:0] != 2'h0 || paddr_in >= 12'h400)
		|=> pslverr_out && prdata_out == 32'h0) else $error("bad address not refused");
	AST_ERR_OK: assert property (s_rd_setup(12'h040) |=> !pslverr_out)
		else $error("mapped address refused");
	AST_STANDS: assert property (!setup |=> $stable(prdata_out) && $stable(pslverr_out))
		else $error("read data moved outside setup");
	AST_STATUS_PINS: assert property (s_pins_calm ##0 s_rd_setup(12'h008)
		|=> prdata_out[15:8] == $past(io_pin_in)) else $error("pin levels not in status");
	AST_STATUS_CELLS: assert property (s_rd_setup(12'h008)
		|=> prdata_out[7:0] == $past(io_pin_out, 2)) else $error("cell outputs not in status");

	for (genvar i = 0; i < NUM_CELL; i++) begin : g_pin
		AST_OE_INPUT: assert property (io_q[i][1:0] == 2'h0 |-> !io_pin_oe_out[i])
			else $error("input-only pin driven");
		AST_OE_TIED: assert property (io_q[i][1:0] inside {2'h1, 2'h2} && io_q[i][5:2] < 4'h2
			|-> io_pin_oe_out[i] == io_q[i][2]) else $error("tied pin enable wrong");
		AST_GCLR: assert property ((!global_clear_low_in && gclr_q[i] && !byp_q[i]) [*5]
			|-> !io_pin_out[i]) else $error("global clear did not clear");
	end
endmodule

bind mrf_fabric mrf_fabric_monitor #(.NUM_CELL(NUM_CELL)) mrf_fabric_monitor_i (
	.core_clk_in, .rst_b_in, .global_clear_low_in, .io_pin_in, .io_pin_out,
	.io_pin_oe_out, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in,
	.prdata_out, .pready_out, .pslverr_out);

/* File: mrf_board_model.sv */
// board logic model: resolves each pin from device and board drivers
`timescale 1ns/1ps
module mrf_board_model #(
	parameter int NUM_CELL = 8
) (
	input  wire logic                core_clk_in,
	input  wire logic [NUM_CELL-1:0] dev_val_in,
	input  wire logic [NUM_CELL-1:0] dev_oe_in,
	input  wire logic [NUM_CELL-1:0] brd_val_in,
	input  wire logic [NUM_CELL-1:0] brd_en_in,
	output logic      [NUM_CELL-1:0] pin_out
);
	logic [NUM_CELL-1:0] last_q = '0;

	// remember the last driven level; no pull exists on these pins
	always_ff @(posedge core_clk_in) begin
		for (int i = 0; i < NUM_CELL; i++) begin
			if (dev_oe_in[i] || brd_en_in[i]) last_q[i] <= pin_out[i];
		end
	end

	// released pin shows the inverse of its last level, never a stale copy
	always_comb begin
		for (int i = 0; i < NUM_CELL; i++) begin
			pin_out[i] = dev_oe_in[i] ? dev_val_in[i] : (brd_en_in[i] ? brd_val_in[i] : ~last_q[i]);
		end
	end
endmodule

/* File: mrf_fabric_tb.sv */
// self-checking bench of the macrocell fabric slice
`timescale 1ns/1ps
module mrf_fabric_tb import mrf_pkg::*;;
	logic        clk, rst_b, ga, gb, oea, gclr_b, psel, pen, pwr, rdy, err, rd_e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd_v;
	logic [7:0]  pin_i, pout, poe, bval, ben;
	int          failures, total_checks;
	localparam logic [11:0] RA [6] = '{12'h000, 12'h004, 12'h040, 12'h080, 12'h0c0, 12'h100};
	localparam logic [31:0] RM [6] = '{32'hfffff, 32'hf, 32'h3ff, 32'h3f, 32'h3f, 32'hfffff};
	localparam logic [11:0] EA [4] = '{12'h00c, 12'h041, 12'h400, 12'h030};
	localparam logic [4:0]  FT [11] = '{5'h05, 5'h00, 5'h0d, 5'h0c, 5'h08, 5'h15, 5'h16,
		5'h12, 5'h1d, 5'h1f, 5'h1a};
	localparam logic [7:0]  OC [5] = '{8'h85, 8'h86, 8'h04, 8'h01, 8'h02};
	localparam logic [7:0]  PU = 8'h5a; // mixed power-up levels so both kinds are seen

	mrf_fabric #(.POWERUP_STATE(PU)) mrf_fabric_i (.core_clk_in(clk), .rst_b_in(rst_b),
		.global_clock_pin_a_in(ga), .global_clock_pin_b_in(gb), .oe_pin_a_in(oea),
		.global_clear_low_in(gclr_b),
		.io_pin_in(pin_i), .io_pin_out(pout), .io_pin_oe_out(poe), .psel_in(psel),
		.penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata), .pready_out(rdy), .pslverr_out(err));
	mrf_board_model mrf_board_model_i (.core_clk_in(clk), .dev_val_in(pout),
		.dev_oe_in(poe), .brd_val_in(bval), .brd_en_in(ben), .pin_out(pin_i));

	// --------------------------------------------------------------
	// clock, tasks
	// --------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask

	task automatic finish_test();
		if (failures == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// apb transfer: held until the edge that samples pready high
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do @(posedge clk); while (rdy !== 1'b1);
		rd_v = prdata;
		rd_e = err;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask

	// clock pin pulse; data settles first since pins pass two sync flops
	task automatic gp(input logic b);
		wt(3);
		{gb, ga} <= b ? 2'b10 : 2'b01;
		wt(5);
		{gb, ga} <= 2'b00;
		wt(5);
	endtask

	initial begin
		#300000;
		failures++;
		finish_test();
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		{rst_b, ga, gb, oea, psel, pen, pwr} = '0;
		gclr_b = 1'b1;
		{paddr, pwdata, bval} = '0;
		ben = 8'h0e;
		failures = 0;
		total_checks = 0;
		wt(10);
		rst_b <= 1'b1;
		wt(1);
		chk(poe, 0);
		chk(pout, PU);
		foreach (RA[k]) begin
			bus(0, RA[k], 0);
			chk(rd_v, 0);
			bus(1, RA[k], '1);
			bus(0, RA[k], 0);
			chk(rd_v, RM[k]);
		end
		foreach (EA[k]) begin
			bus(0, EA[k], 0);
			chk(rd_e, 1);
			chk(rd_v, 0);
		end
		bus(1, 12'h042, 0);
		bus(0, 12'h040, 0);
		chk(rd_v, 32'h3ff);
		// pin 0 shows cell 0; sum from pin 1, second term from pin 3
		bus(1, 12'h080, 32'h05);
		bus(1, 12'h004, 32'h4);
		bus(1, 12'h100, 32'h20);
		bus(1, 12'h104, 0);
		bus(1, 12'h110, 32'h80);
		bus(1, 12'h114, 0);
		foreach (FT[k]) begin
			bus(1, 12'h040, {30'h0, FT[k][4:3]});
			bval[1] <= FT[k][2];
			bval[3] <= FT[k][1];
			gp(0);
			chk(pout[0], FT[k][0]);
		end
		bval[3] <= 1'b0;
		bus(1, 12'h004, 32'hc);
		bus(1, 12'h040, 32'h20);
		bval[1] <= 1'b1;
		wt(3);
		gb <= 1'b1;
		wt(5);
		chk(pout[0], 0);
		gb <= 1'b0;
		wt(5);
		chk(pout[0], 1);
		bval[1] <= 1'b0;
		gp(0);
		chk(pout[0], 1);
		bus(1, 12'h040, 0);
		bus(1, 12'h000, 32'hfffdf);
		bval[1] <= 1'b1;
		gp(0);
		chk(pout[0], 0);
		bus(1, 12'h000, 32'hfffff);
		gp(0);
		chk(pout[0], 1);
		bus(1, 12'h040, 32'h08);
		bus(1, 12'h118, 32'h40);
		bval[2:1] <= 2'b00;
		gp(0);
		chk(pout[0], 1);
		bval[2] <= 1'b1;
		gp(0);
		chk(pout[0], 0);
		bus(1, 12'h040, 32'h10);
		bval[2:1] <= 2'b01;
		wt(5);
		bval[2] <= 1'b1;
		wt(5);
		chk(pout[0], 1);
		bval[1] <= 1'b0;
		gp(0);
		chk(pout[0], 1);
		bus(1, 12'h040, 32'h04);
		wt(4);
		chk(pout[0], 0);
		bval[1] <= 1'b1;
		wt(4);
		chk(pout[0], 1);
		wt(2);
		bus(0, 12'h008, 0);
		chk(rd_v[11:9], bval[3:1]);
		bus(1, 12'h040, 32'h40);
		gp(0);
		gclr_b <= 1'b0;
		wt(6);
		chk(pout[0], 0);
		gclr_b <= 1'b1;
		bus(1, 12'h040, 0);
		gp(0);
		gclr_b <= 1'b0;
		wt(6);
		chk(pout[0], 1);
		gclr_b <= 1'b1;
		bval[1] <= 1'b0;
		gp(0);
		bus(1, 12'h120, 32'h40);
		wt(3);
		chk(pout[0], 1);
		bus(1, 12'h128, 32'h80);
		bval[3] <= 1'b1;
		wt(4);
		chk(pout[0], 0);
		bus(1, 12'h120, 0);
		bus(1, 12'h128, 0);
		bus(1, 12'h124, 32'h40);
		bval[3:2] <= 2'b00;
		wt(4);
		chk(pout[0], 1);
		bus(1, 12'h124, 0);
		foreach (OC[k]) begin
			bus(1, 12'h080, {24'h0, OC[k]});
			wt(1);
			chk(poe[0], OC[k][7]);
		end
		bus(1, 12'h0c0, 32'h02);
		bus(1, 12'h080, 32'h09);
		oea <= 1'b1;
		wt(3);
		chk(poe[0], 1);
		oea <= 1'b0;
		wt(3);
		chk(poe[0], 0);
		bus(1, 12'h0c0, 32'h26);
		wt(3);
		chk(poe[0], 1);
		bus(1, 12'h080, 0);
		ben[0] <= 1'b1;
		for (int f = 0; f < 2; f++) begin
			bus(1, 12'h040, f ? 32'h180 : 32'h80);
			bval[1:0] <= 2'b01;
			gp(0);
			chk(pout[0], 1);
			bval[1:0] <= 2'b10;
			gp(0);
			chk(pout[0], 0);
		end
		// pin and clock move together: the delay stage still holds the old level
		bval[0] <= 1'b1;
		ga <= 1'b1;
		wt(5);
		ga <= 1'b0;
		wt(5);
		chk(pout[0], 0);
		bus(1, 12'h040, 32'h80);
		bval[0] <= 1'b0;
		wt(5);
		bval[0] <= 1'b1;
		ga <= 1'b1;
		wt(5);
		ga <= 1'b0;
		wt(5);
		chk(pout[0], 1);
		bus(1, 12'h040, 32'h200);
		bus(1, 12'h044, 32'h04);
		bval[3] <= 1'b1;
		wt(4);
		chk(pout[1], 1);
		bus(1, 12'h040, 0);
		wt(2);
		chk(pout[1], 0);
		// reset in mid-run: config cleared, cells back at their power-up levels
		rst_b <= 1'b0;
		wt(2);
		rst_b <= 1'b1;
		wt(1);
		chk(pout, PU);
		chk(poe, 0);
		bus(0, 12'h044, 0);
		chk(rd_v, 0);
		finish_test();
	end
endmodule
